// ===== verilog/secure_write_commit_tamper.sv
// Commit, reset-delay and tamper control of the secure EEPROM core.
// Assumes a two_wire_serial_bus front end that decodes commands into one-cycle events and an array with a start pulse.
`timescale 1ns/100ps
module secure_write_commit_tamper
  import commit_pkg::*;
#(
  parameter int PROG_CNT = commit_pkg::PROG_CYCLES,
  parameter int POR_CNT  = commit_pkg::POR_CYCLES
) (
  // Clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        nrst_i,
  // Sensors
  input  wire commit_pkg::sensor_t         sensor_i,
  // Bus front end events
  input  wire logic                        addr_match_i,
  input  wire logic                        stop_i,
  input  wire logic                        bus_activity_i,
  input  wire commit_pkg::wr_req_t         wr_i,
  input  wire logic                        csum_valid_i,
  input  wire logic [commit_pkg::CSUM_W-1:0] csum_i,
  input  wire logic                        cmd_valid_i,
  // Crypto engine
  input  wire logic [commit_pkg::CSUM_W-1:0] engine_csum_i,
  input  wire logic                        auth_set_i,
  input  wire logic                        encr_set_i,
  output logic                             engine_reset_o,
  // Array
  output logic                             prog_start_o,
  output commit_pkg::wr_req_t              prog_o,
  // Status
  output logic                             addr_ack_o,
  output logic                             cmd_exec_o,
  output logic                             tamper_o,
  output commit_pkg::sec_flags_t           sec_flags_o,
  output logic                             pending_o
);
  import commit_pkg::*;

  typedef enum {S_TAMPER, S_DELAY, S_IDLE, S_HOLD, S_WAIT_STOP, S_PROG} state_t;

  state_t     state_q, state_d;
  wr_req_t    buf_q, buf_d;
  sec_flags_t flags_q, flags_d;
  logic       prog_start_q, prog_start_d;
  logic       eng_rst_q, eng_rst_d;
  logic       timer_load;
  logic [23:0] timer_cnt;
  logic       timer_busy;
  logic       tamper;
  logic       secure;

  assign tamper = sensor_i.supply_bad | sensor_i.clock_bad | sensor_i.light_bad; // RQ4
  assign secure = flags_q.auth | flags_q.encr;

  ready_timer #(.CNT_W(24)) u_timer (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .load_i    (timer_load),
    .count_i   (timer_cnt),
    .busy_o    (timer_busy)
  );

  always_comb
  begin
    state_d      = state_q;
    buf_d        = buf_q;
    flags_d      = flags_q;
    prog_start_d = 1'b0;
    eng_rst_d    = 1'b0;
    timer_load   = 1'b0;
    timer_cnt    = 24'(POR_CNT);
    if (tamper)
    begin
      state_d      = S_TAMPER; // RQ5
      buf_d        = '0;
      flags_d      = sec_flags_t'(SEC_RESET); // RQ3
    end
    else
    begin
      case (state_q)
        S_TAMPER:
        begin
          state_d    = S_DELAY; // RQ12
          timer_load = 1'b1; // RQ2
          flags_d    = sec_flags_t'(SEC_RESET); // RQ3
          eng_rst_d  = 1'b1;
        end
        S_DELAY:
        begin
          if (!timer_busy)
          begin
            state_d = S_IDLE;
          end
        end
        S_IDLE:
        begin
          if (auth_set_i)
          begin
            flags_d.auth = 1'b1;
          end
          if (encr_set_i)
          begin
            flags_d.encr = 1'b1;
          end
          if (wr_i.valid)
          begin
            buf_d   = wr_i;
            state_d = secure ? S_HOLD : S_WAIT_STOP; // RQ6
          end
        end
        S_HOLD:
        begin
          if (csum_valid_i)
          begin
            if (csum_i == engine_csum_i)
            begin
              state_d = S_WAIT_STOP; // RQ8
            end
            else
            begin
              buf_d     = '0; // RQ9
              eng_rst_d = 1'b1;
              state_d   = S_IDLE;
            end
          end
          else if (bus_activity_i)
          begin
            buf_d   = '0; // RQ10
            state_d = S_IDLE;
          end
        end
        S_WAIT_STOP:
        begin
          if (stop_i)
          begin
            prog_start_d = 1'b1;
            timer_load   = 1'b1; // RQ1
            timer_cnt    = 24'(PROG_CNT);
            state_d      = S_PROG;
          end
        end
        S_PROG:
        begin
          if (!timer_busy && !prog_start_q)
          begin
            buf_d   = '0;
            state_d = S_IDLE;
          end
        end
        default:
        begin
          state_d = S_TAMPER;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q      <= S_TAMPER;
      buf_q        <= '0;
      flags_q      <= sec_flags_t'(SEC_RESET);
      prog_start_q <= 1'b0;
      eng_rst_q    <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      buf_q        <= buf_d;
      flags_q      <= flags_d;
      prog_start_q <= prog_start_d;
      eng_rst_q    <= eng_rst_d;
    end
  end

  assign addr_ack_o     = addr_match_i && (state_q inside {S_IDLE, S_HOLD, S_WAIT_STOP}) && !tamper; // RQ11
  assign cmd_exec_o     = cmd_valid_i && (state_q == S_IDLE) && !tamper; // RQ5
  assign tamper_o       = (state_q == S_TAMPER);
  assign prog_start_o   = prog_start_q;
  assign prog_o         = buf_q;
  assign engine_reset_o = eng_rst_q;
  assign sec_flags_o    = flags_q;
  assign pending_o      = (state_q == S_HOLD);

  tamper_blocks_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    tamper |-> (!addr_ack_o && !cmd_exec_o) ##1 (state_q == S_TAMPER)) // RQ5
    else $error("command path open during tamper");
  flags_cleared_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == S_TAMPER) && !tamper |=> (flags_q == sec_flags_t'(SEC_RESET)) && (state_q == S_DELAY)) // RQ3
    else $error("flags not cleared by reset sequence");
  delay_nak_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == S_DELAY) |-> !addr_ack_o) // RQ11
    else $error("address acked during reset delay");
  hold_no_prog_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == S_HOLD) |=> !prog_start_o) // RQ6
    else $error("program started before checksum");
  bad_csum_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == S_HOLD) && csum_valid_i && (csum_i != engine_csum_i) && !tamper
      |=> engine_reset_o && (state_q == S_IDLE) && !buf_q.valid) // RQ9
    else $error("mismatch did not discard");
  good_csum_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == S_HOLD) && csum_valid_i && (csum_i == engine_csum_i) && !tamper
      |=> (state_q == S_WAIT_STOP) && buf_q.valid) // RQ8
    else $error("match did not keep buffer");
  activity_abort_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == S_HOLD) && bus_activity_i && !csum_valid_i && !tamper
      |=> (state_q == S_IDLE) ##1 !prog_start_o) // RQ10
    else $error("pending write not abandoned");
  prog_from_stop_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == S_WAIT_STOP) && stop_i && !tamper |=> prog_start_o && timer_busy) // RQ1
    else $error("program cycle not started at stop");
  prog_nak_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == S_PROG) |-> !addr_ack_o) // RQ11
    else $error("address acked while programming");
  sensor_tamper_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    sensor_i.light_bad |=> tamper_o) // RQ4
    else $error("light sensor not treated as tamper");
  release_delay_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $fell(tamper_o) |-> (state_q == S_DELAY) && timer_busy) // RQ2
    else $error("no delay after tamper release");
  no_skip_delay_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == S_IDLE) |-> $past(state_q) != S_TAMPER) // RQ12
    else $error("reset sequence skipped");
endmodule : secure_write_commit_tamper

// ===== verilog/commit_pkg.sv
// Constants and carrier types for the secure write commit and tamper control block.
// Assumes one 250 MHz clock and an upstream bus decoder that reports commands as one-cycle events.
// What this block does
// RQ1: The write cycle time is counted from the stop that ends a write until the clear-and-program cycle is done.
// RQ2: After any power-up or tamper reset the block refuses operation for a fixed delay once conditions are normal.
// RQ3: The reset sequence returns every security flag, authentication and encryption, to its initial value.
// RQ4: Supply, clock frequency and light sensors are watched all the time and any out-of-limit flag is tamper.
// RQ5: While tamper is seen the block is disabled and runs no command at all.
// RQ6: A user-zone write in authentication or encryption mode is buffered and not programmed before a checksum.
// RQ7: The host sends the checksum command right after the user-zone write.
// RQ8: A matching checksum programs the buffered data into the user zone.
// RQ9: A mismatching checksum discards the buffer and resets the crypto engine.
// RQ10: Any bus activity between the buffered write and the checksum may abort the write, leaving the zone unchanged.
// RQ11: The bus address is not acknowledged while programming or during the post-reset delay.
// RQ12: Tamper disable holds until sensors return to limits, then the full reset sequence runs.
package commit_pkg;

  localparam int          CLK_MHZ        = 250;
  localparam int          PROG_TIME_US   = 5000;
  localparam int          PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
  localparam int          POR_DELAY_US   = 100;
  localparam int          POR_CYCLES     = POR_DELAY_US * CLK_MHZ;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;
  localparam int          CSUM_W         = 16;
  localparam logic [1:0]  SEC_RESET      = 2'h0;

  typedef struct packed {
    logic supply_bad;
    logic clock_bad;
    logic light_bad;
  } sensor_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wr_req_t;

  typedef struct packed {
    logic auth;
    logic encr;
  } sec_flags_t;

endpackage : commit_pkg

// ===== verilog/ready_timer.sv
// Down counter that reports busy while a loaded count runs out.
// Assumes the loading logic holds load high for one cycle.
`timescale 1ns/100ps
module ready_timer #(
  parameter int CNT_W = 24
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  // Control
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] count_i,
  // Status
  output logic                  busy_o
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (load_i)
    begin
      cnt_d = count_i;
    end
    else if (cnt_q != '0)
    begin
      cnt_d = cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign busy_o = (cnt_q != '0);

  busy_tracks_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    load_i && (count_i > CNT_W'(1)) |=> busy_o)
    else $error("timer not busy after load");
endmodule : ready_timer

// ===== test/host_model.sv
// Host side model of the decoded two-wire bus events.
// Assumes one caller thread and the block's clock.
`timescale 1ns/100ps
module host_model
  import commit_pkg::*;
(
  input  wire logic   sys_clk_i,
  input  wire logic   ack_i,
  input  wire logic   exec_i,
  output logic        addr_match_o,
  output logic        stop_o,
  output logic        act_o,
  output wr_req_t     wr_o,
  output logic        csum_valid_o,
  output logic [15:0] csum_o,
  output logic        cmd_valid_o
);
  initial {addr_match_o, stop_o, act_o, wr_o, csum_valid_o, csum_o, cmd_valid_o} = '0;
  task step;
    @(posedge sys_clk_i);
    #1;
  endtask : step
  // Mode 0 plain, 1 with checksum, 2 stray activity instead of checksum
  task write(input logic [7:0] a, input logic [7:0] d, input logic [15:0] c, input int mode);
    step;
    wr_o = {1'b1, a, d};
    step;
    wr_o = {1'b0, ~a, ~d};
    if (mode == 1)
    begin
      {csum_valid_o, csum_o} = {1'b1, c};
      step;
      {csum_valid_o, csum_o} = {1'b0, ~c};
    end
    act_o = (mode == 2);
    step;
    {act_o, stop_o} = 2'b01;
    step;
    stop_o = 0;
  endtask : write
  task poll(output int n);
    n = 0;
    step;
    addr_match_o = 1;
    #1;
    while (ack_i !== 1'b1 && n < 200)
    begin
      step;
      n++;
    end
    addr_match_o = 0;
  endtask : poll
  task try(output logic a, output logic e);
    step;
    {addr_match_o, cmd_valid_o} = 2'b11;
    #1 {a, e} = {ack_i, exec_i};
    step;
    {addr_match_o, cmd_valid_o} = 2'b00;
  endtask : try
endmodule : host_model

// ===== test/testbench.sv
// Self-checking bench of the secure write commit and tamper block.
// Assumes host_model drives the bus events; shortened counts.
`timescale 1ns/100ps
module testbench;
  import commit_pkg::*;
  localparam int PC = 20;
  localparam int RC = 10;
  logic clk, nrst, auth_set, encr_set, addr_match, stop, act, csum_valid, cmd_valid;
  logic eng_rst, prog_start, ack, exec, tamper, pending, a, e, pend_seen;
  logic [15:0] engine_csum, csum;
  logic [7:0] ad, dd;
  sensor_t sensor;
  wr_req_t wr, prog;
  sec_flags_t flags, fl_m;
  logic [16:0] got_q[$], exp_q[$];
  int error_cnt, n_tests, n, er_cnt;
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  secure_write_commit_tamper #(.PROG_CNT(PC), .POR_CNT(RC)) u_secure_write_commit_tamper (
    .sys_clk_i(clk), .nrst_i(nrst), .sensor_i(sensor), .addr_match_i(addr_match),
    .stop_i(stop), .bus_activity_i(act), .wr_i(wr), .csum_valid_i(csum_valid), .csum_i(csum),
    .cmd_valid_i(cmd_valid), .engine_csum_i(engine_csum), .auth_set_i(auth_set),
    .encr_set_i(encr_set), .engine_reset_o(eng_rst), .prog_start_o(prog_start), .prog_o(prog),
    .addr_ack_o(ack), .cmd_exec_o(exec), .tamper_o(tamper), .sec_flags_o(flags), .pending_o(pending));
  host_model u_host_model (
    .sys_clk_i(clk), .ack_i(ack), .exec_i(exec), .addr_match_o(addr_match), .stop_o(stop),
    .act_o(act), .wr_o(wr), .csum_valid_o(csum_valid), .csum_o(csum), .cmd_valid_o(cmd_valid));
  always @(posedge clk)
  begin
    if (prog_start === 1'b1) got_q.push_back(prog);
    if (eng_rst === 1'b1) er_cnt++;
    if (pending === 1'b1) pend_seen = 1;
  end
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, s, x);
    end
  endtask : chk
  task close_out;
    $display("counts: checks=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task step;
    @(posedge clk);
    #1;
  endtask : step
  task run(input int mode, input int bad);
    {ad, dd, engine_csum} = $urandom;
    {auth_set, encr_set} = {mode != 0, bad != 0};
    fl_m = sec_flags_t'(fl_m | {mode != 0, bad != 0});
    step;
    {auth_set, encr_set, er_cnt, pend_seen} = '0;
    chk(flags, fl_m);
    u_host_model.write(ad, dd, engine_csum ^ 16'(bad), mode);
    step;
    if (mode == 0 || (mode == 1 && bad == 0)) exp_q.push_back({1'b1, ad, dd});
    chk(got_q.size(), exp_q.size());
    while (exp_q.size() > 0 && got_q.size() > 0) chk(got_q.pop_front(), exp_q.pop_front());
    if (mode != 0) chk({pend_seen, pending}, 2'b10);
    if (mode == 1) chk(er_cnt, bad != 0);
    u_host_model.poll(n);
    if (got_q.size() + exp_q.size() == 0 && (mode == 0 || (mode == 1 && bad == 0)))
      chk(32'(n >= PC - 4 && n <= PC + 4), 1);
    else
      chk(32'(n <= 1), 1);
    got_q.delete();
    exp_q.delete();
    $display("test mode %0d bad %0d done", mode, bad);
  endtask : run
  initial
  begin
    void'($urandom(32'hDADCF260));
    {sensor, engine_csum, auth_set, encr_set, nrst, error_cnt, n_tests, fl_m} = '0;
    repeat (2) @(posedge clk);
    #1 nrst = 1;
    u_host_model.poll(n);
    chk(32'(n >= RC && n <= RC + 4), 1);
    chk(flags, 2'h0);
    u_host_model.try(a, e);
    chk({a, e}, 2'b11);
    $display("test reset done");
    run(0, 0);
    run(1, 0);
    run(1, 1);
    run(2, 0);
    for (int i = 0; i < 3; i++)
    begin
      auth_set = 1;
      step;
      auth_set = 0;
      sensor = sensor_t'(3'h1 << i);
      repeat (3) step;
      u_host_model.try(a, e);
      chk({tamper, flags, a, e}, 5'b10000);
      sensor = '0;
      u_host_model.poll(n);
      chk(32'(n >= RC && n <= RC + 4), 1);
      $display("test tamper %0d done", i);
    end
    close_out();
  end
  initial
  begin
    #20000;
    error_cnt++;
    close_out();
  end
endmodule : testbench
